//--- dv/dtse_sink.sv
// Tone sink in place of the modulator or audio output stage
`default_nettype none
module dtse_sink
  import dtse_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic [1:0]             pace,
  input  wire logic                   tone_valid,
  input  wire logic [DTSE_TONE_W-1:0] tone_data,
  output var  logic                   tone_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pace 0 takes all, 1 stalls at random, 2 halts so the buffer must hold tones
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      tone_ready <= 1'b0;
    else
      tone_ready <= pace == 2'd0 || (pace == 2'd1 && $urandom_range(0, 2) != 0);
  end
endmodule : dtse_sink
`default_nettype wire

//--- dv/dtse_top_sva.sv
// Port-level checks on the dual-tone sequence encoder
`default_nettype none
module dtse_sva
  import dtse_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   reset_n,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [7:0]             wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   tone_valid,
  input wire logic                   tone_ready,
  input wire logic [DTSE_TONE_W-1:0] tone_data,
  input wire logic                   tone_output_route,
  input wire logic                   preemp_en,
  input wire logic                   dc_coupling,
  input wire logic                   sending
);
  timeunit 1ns;
  timeprecision 1ps;
  logic                    take;
  logic                    wr;
  logic                    send_wr;
  logic                    stop_wr;
  logic                    ctrl_wr;
  logic [DTSE_LEVEL_W-1:0] lvl_q;
  dtse_tone_t              tone;
  // Bus events decoded once; a write lands at its taking edge
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign send_wr = wr && wb_adr_i == DTSE_CMD_ADDR && wb_dat_i[DTSE_SEND_BIT];
  assign stop_wr = wr && wb_adr_i == DTSE_CMD_ADDR && wb_dat_i[DTSE_STOP_BIT];
  assign ctrl_wr = wr && wb_adr_i == DTSE_CTRL_ADDR;
  assign tone = tone_data;
  // Last level written, so each tone's split can be judged
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      lvl_q <= '0;
    else if (wr && wb_adr_i == DTSE_LEVEL_ADDR)
      lvl_q <= wb_dat_i[DTSE_LEVEL_W-1:0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_held; tone_valid && !tone_ready; endsequence
  sequence s_sent; tone_valid && tone_ready; endsequence
  property p_ack; take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not acknowledged");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_unmapped; (take && !wb_we_i && wb_adr_i >= 8'h60) |=> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; s_held && !stop_wr |=> tone_valid && $stable(tone_data); endproperty
  a_hold: assert property (p_hold) else $error("tone dropped before accept");
  property p_drop; s_sent |=> !tone_valid; endproperty
  a_drop: assert property (p_drop) else $error("tone valid not dropped after accept");
  property p_stop; stop_wr |-> ##[1:2] !sending; endproperty
  a_stop: assert property (p_stop) else $error("stop did not idle sequencer");
  property p_start; $rose(sending) |-> $past(send_wr) || $past(send_wr, 2); endproperty
  a_start: assert property (p_start) else $error("sending rose without send");
  property p_pins;
    !$stable({tone_output_route, preemp_en, dc_coupling}) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  a_pins: assert property (p_pins) else $error("output pins moved on their own");
  property p_dc; dc_coupling |-> tone_output_route; endproperty
  a_dc: assert property (p_dc) else $error("dc coupling without audio route");
  property p_level; s_sent |-> lvl_q != 0 && tone.low_level + tone.high_level == lvl_q; endproperty
  a_level: assert property (p_level) else $error("tone pair peak differs from level");
endmodule : dtse_sva
`default_nettype wire

//--- dv/dtse_top_test.sv
// Self-checking bench for the dual-tone sequence encoder
`default_nettype none
module dtse_top_test
  import dtse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  // Keypad place of each symbol code, row times four plus column
  localparam logic [3:0] KEY [16] = '{4'hd, 4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8,
                                      4'h9, 4'ha, 4'hc, 4'he, 4'h3, 4'h7, 4'hb, 4'hf};
  logic                   mclk = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   wb_cyc_i = 1'b0;
  logic                   wb_stb_i = 1'b0;
  logic                   wb_we_i = 1'b0;
  logic [7:0]             wb_adr_i = 8'h00;
  logic [3:0]             wb_sel_i = 4'h0;
  logic [31:0]            wb_dat_i = 32'h0;
  logic [1:0]             pace = 2'd0;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  logic                   tone_valid;
  logic                   tone_ready;
  logic [DTSE_TONE_W-1:0] tone_data;
  logic                   tone_output_route;
  logic                   preemp_en;
  logic                   dc_coupling;
  logic                   sending;
  logic [31:0]            exp_rd[$];
  logic [31:0]            exp_mask[$];
  dtse_tone_t             exp_tone[$];
  logic [DTSE_FREQ_W-1:0] freq [8];
  logic [3:0]             seq [8];
  logic [31:0]            mon_m;
  int                     miscompares = 0;
  int                     compares = 0;
  int                     lvl, tw, pre, seq_n, cyc_n = 0, last_t = -1;
  bit                     gap_chk = 0;
  always #5 mclk = ~mclk;
  dtse_top #(.TICK_CYC(TICK), .FIFO_DEPTH(4)) dtse_top_i (.mclk(mclk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tone_valid(tone_valid), .tone_ready(tone_ready), .tone_data(tone_data),
    .tone_output_route(tone_output_route), .preemp_en(preemp_en), .dc_coupling(dc_coupling),
    .sending(sending));
  dtse_sink dtse_sink_i (.mclk(mclk), .reset_n(reset_n), .pace(pace), .tone_valid(tone_valid),
    .tone_data(tone_data), .tone_ready(tone_ready));
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One classic cycle; signals move just after an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    check("bus ack", 1'b1, wb_ack_o);
    if (wb_ack_o !== 1'b1)
      finish_test();
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_rd.push_back(e);
    exp_mask.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask : rd
  // Expected pair: keypad lookup, then the linear twist and emphasis split
  function automatic dtse_tone_t tone_of(input logic [3:0] s);
    dtse_tone_t t;
    int h;
    h = lvl * (128 + tw + pre * 32) / 256;
    t.row_freq = freq[KEY[s][3:2]];
    t.col_freq = freq[4 + KEY[s][1:0]];
    t.high_level = 12'(h);
    t.low_level = 12'(lvl - h);
    return t;
  endfunction : tone_of
  task automatic setup(input int n);
    seq_n = n;
    for (int i = 0; i < n; i++)
    begin
      seq[i] = 4'($urandom_range(0, 15));
      wb(1'b1, DTSE_SEQ_ADDR + 8'(4 * i), 32'(seq[i]));
    end
    wb(1'b1, DTSE_SEQLEN_ADDR, 32'(n));
  endtask : setup
  task automatic send(input logic [1:0] m, input int passes);
    wb(1'b1, DTSE_CTRL_ADDR, {16'h0, 8'(tw), 4'h0, 1'(pre), 1'b0, m});
    for (int p = 0; p < passes; p++)
      for (int i = 0; i < seq_n; i++)
        exp_tone.push_back(tone_of(seq[i]));
    wb(1'b1, DTSE_CMD_ADDR, 32'h1);
  endtask : send
  // Bounded wait for idle with every noted tone delivered
  task automatic wait_done();
    int n;
    n = 0;
    repeat (3) @(posedge mclk);
    while ((sending !== 1'b0 || exp_tone.size() != 0) && n < 5000)
    begin
      @(posedge mclk);
      n++;
    end
    check("run finished", 1'b1, n < 5000);
    if (n >= 5000)
      finish_test();
  endtask : wait_done
  // Watcher: oldest note against each result that appears
  always @(posedge mclk)
  begin
    cyc_n++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_mask.size() > 0)
    begin
      mon_m = exp_mask.pop_front();
      check("read data", exp_rd.pop_front() & mon_m, wb_dat_o & mon_m);
    end
    if (tone_valid === 1'b1 && tone_ready === 1'b1)
    begin
      if (exp_tone.size() == 0)
        check("unexpected tone", 1'b0, 1'b1);
      else
        check("tone", exp_tone.pop_front(), tone_data);
      if (gap_chk && last_t >= 0)
        check("tone spacing", (2 + 1) * TICK, cyc_n - last_t);
      last_t = cyc_n;
    end
  end
  initial
  begin
    repeat (90000) @(posedge mclk);
    check("watchdog", 1'b0, 1'b1);
    finish_test();
  end
  initial
  begin
    void'($urandom(45));
    for (int i = 0; i < 8; i++)
      freq[i] = DTSE_STD_FREQ[i];
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    check("pins after reset", 5'h0, {tone_output_route, preemp_en, dc_coupling, sending,
      tone_valid});
    rd(DTSE_CTRL_ADDR, 32'h0, 32'hffffffff);
    rd(DTSE_STATUS_ADDR, 32'h0, 32'h3);
    rd(8'h60, 32'h0, 32'hffffffff);
    for (int i = 0; i < 8; i++)
      rd(DTSE_FREQ_ADDR + 8'(4 * i), 32'(freq[i]), 32'hffff);
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, DTSE_CTRL_ADDR, 32'(i) << 2);
      repeat (2) @(posedge mclk);
      check("route pins", {i[0], i[1], i[2] & i[0]},
        {tone_output_route, preemp_en, dc_coupling});
    end
    $display("test reset and pins done");
    // Shaping and timing set once; a rewritten frequency must be used
    lvl = $urandom_range(1, 4095);
    tw = int'($urandom_range(0, 127)) - 64;
    pre = $urandom_range(0, 1);
    freq[0] = 16'($urandom_range(1, 65535));
    wb(1'b1, DTSE_FREQ_ADDR, 32'(freq[0]));
    wb(1'b1, DTSE_ONTIME_ADDR, 32'h2);
    wb(1'b1, DTSE_OFFTIME_ADDR, 32'h1);
    wb(1'b1, DTSE_LEVEL_ADDR, 32'(lvl));
    wb(1'b1, DTSE_BURSTS_ADDR, 32'h3);
    // Step first, from a fresh position: one symbol per send
    setup(4);
    wb(1'b1, DTSE_CTRL_ADDR, {16'h0, 8'(tw), 4'h0, 1'(pre), 1'b0, DTSE_STEP});
    for (int k = 0; k < 3; k++)
    begin
      exp_tone.push_back(tone_of(seq[k]));
      wb(1'b1, DTSE_CMD_ADDR, 32'h1);
      wait_done();
    end
    $display("test step done");
    // Single with a burst count standing, then burst under random stalls
    setup($urandom_range(3, 8));
    gap_chk = 1;
    last_t = -1;
    send(DTSE_SINGLE, 1);
    wait_done();
    gap_chk = 0;
    pace <= 2'd1;
    send(DTSE_BURST, 3);
    wait_done();
    $display("test single and burst done");
    // Sink halted while four tones pile up in the buffer
    setup(4);
    pace <= 2'd2;
    send(DTSE_SINGLE, 1);
    repeat (100) @(posedge mclk);
    pace <= 2'd0;
    wait_done();
    wb(1'b1, DTSE_CMD_ADDR, 32'h4);
    freq[0] = DTSE_STD_FREQ[0];
    rd(DTSE_FREQ_ADDR, 32'(freq[0]), 32'hffff);
    $display("test buffer and reload done");
    // Continuous replay, stopped once two passes are out
    setup($urandom_range(2, 4));
    send(DTSE_CONT, 3);
    for (int n = 0; n < 2000 && exp_tone.size() > seq_n; n++)
      @(posedge mclk);
    check("replayed", 1'b1, exp_tone.size() <= seq_n);
    if (exp_tone.size() > seq_n)
      finish_test();
    wb(1'b1, DTSE_CMD_ADDR, 32'h2);
    exp_tone.delete();
    rd(DTSE_STATUS_ADDR, 32'h0, 32'h3);
    check("sending after stop", 1'b0, sending);
    repeat (60) @(posedge mclk);
    // Level zero turns the output off
    wb(1'b1, DTSE_LEVEL_ADDR, 32'h0);
    send(DTSE_SINGLE, 0);
    wait_done();
    repeat (30) @(posedge mclk);
    $display("test continuous and level done");
    finish_test();
  end
endmodule : dtse_top_test
bind dtse_top dtse_sva dtse_sva_i (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tone_valid(tone_valid),
  .tone_ready(tone_ready), .tone_data(tone_data), .tone_output_route(tone_output_route),
  .preemp_en(preemp_en), .dc_coupling(dc_coupling), .sending(sending));
`default_nettype wire

//--- rtl/dtse_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none
module dtse_fifo
  import dtse_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  input  wire logic             flush
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("dtse_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_wr;
  logic             do_rd;
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  // Pointers; flush drops everything queued, used when output stops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
  // Storage has no reset; only valid entries are ever read
  always_ff @(posedge mclk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : dtse_fifo
`default_nettype wire

//--- rtl/dtse_pkg.sv
// Package for the dual-tone sequence encoder: register map, fields, types
`default_nettype none
package dtse_pkg;
  // Register byte offsets
  localparam logic [7:0] DTSE_CTRL_ADDR     = 8'h00;
  localparam logic [7:0] DTSE_CMD_ADDR      = 8'h04;
  localparam logic [7:0] DTSE_ONTIME_ADDR   = 8'h08;
  localparam logic [7:0] DTSE_OFFTIME_ADDR  = 8'h0c;
  localparam logic [7:0] DTSE_BURSTS_ADDR   = 8'h10;
  localparam logic [7:0] DTSE_LEVEL_ADDR    = 8'h14;
  localparam logic [7:0] DTSE_SEQLEN_ADDR   = 8'h18;
  localparam logic [7:0] DTSE_STATUS_ADDR   = 8'h1c;
  localparam logic [7:0] DTSE_SEQ_ADDR      = 8'h20;
  localparam logic [7:0] DTSE_FREQ_ADDR     = 8'h40;
  // Control field positions
  localparam int DTSE_MODE_LSB  = 0;
  localparam int DTSE_ROUTE_BIT = 2;
  localparam int DTSE_PREEMP_BIT = 3;
  localparam int DTSE_DCCPL_BIT = 4;
  localparam int DTSE_TWIST_LSB = 8;
  // Command bits
  localparam int DTSE_SEND_BIT = 0;
  localparam int DTSE_STOP_BIT = 1;
  localparam int DTSE_LOAD_BIT = 2;
  // Field widths
  localparam int DTSE_FREQ_W  = 16;
  localparam int DTSE_TIME_W  = 16;
  localparam int DTSE_LEVEL_W = 12;
  localparam int DTSE_TWIST_W = 8;
  localparam int DTSE_SEQ_MAX = 16;
  localparam int DTSE_SYM_W   = 4;
  // Time base: on/off times are in milliseconds
  localparam int DTSE_CLK_HZ  = 100_000_000;
  localparam int DTSE_TICK_MS = 1;
  localparam int DTSE_TICK_CYC = DTSE_CLK_HZ / 1000 * DTSE_TICK_MS;
  // Default tone table in tenths of Hz (rows then columns)
  localparam logic [DTSE_FREQ_W-1:0] DTSE_STD_FREQ [8] = '{
    16'h1b3a, 16'h1e14, 16'h2148, 16'h24c2,
    16'h2f3a, 16'h3430, 16'h39b2, 16'h3fca};
  localparam logic [7:0] DTSE_RESET_LEVEL = 8'h00;
  // Send modes
  typedef enum logic [1:0] {
    DTSE_SINGLE = 2'b00,
    DTSE_BURST  = 2'b01,
    DTSE_CONT   = 2'b10,
    DTSE_STEP   = 2'b11
  } dtse_mode_t;
  // Sequencer states
  typedef enum logic [1:0] {
    DTSE_IDLE = 2'b00,
    DTSE_ON   = 2'b01,
    DTSE_OFF  = 2'b10
  } dtse_state_t;
  // One emitted tone pair with its shaping
  typedef struct packed {
    logic [DTSE_FREQ_W-1:0]  row_freq;
    logic [DTSE_FREQ_W-1:0]  col_freq;
    logic [DTSE_LEVEL_W-1:0] low_level;
    logic [DTSE_LEVEL_W-1:0] high_level;
  } dtse_tone_t;
  localparam int DTSE_TONE_W = $bits(dtse_tone_t);
endpackage : dtse_pkg
`default_nettype wire

//--- rtl/dtse_top.sv
// Dual-tone sequence encoder: Wishbone registers, sequencer, tone shaping, output FIFO
//
// Implementation choices: the Wishbone register port and the address map.
`default_nettype none
module dtse_top
  import dtse_pkg::*;
#(
  parameter int TICK_CYC   = DTSE_TICK_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output var  logic [31:0]            wb_dat_o,
  output var  logic                   wb_ack_o,
  output var  logic                   tone_valid,
  input  wire logic                   tone_ready,
  output var  logic [DTSE_TONE_W-1:0] tone_data,
  output var  logic                   tone_output_route,
  output var  logic                   preemp_en,
  output var  logic                   dc_coupling,
  output var  logic                   sending
);
  initial
  begin
    if (TICK_CYC < 1 || TICK_CYC > 2**24)
      $error("dtse_top: TICK_CYC out of range");
  end
  // Configuration registers
  logic [4:0]              ctrl_bits;
  logic [DTSE_TWIST_W-1:0] twist;
  logic [DTSE_TIME_W-1:0]  on_time;
  logic [DTSE_TIME_W-1:0]  off_time;
  logic [15:0]             burst_count;
  logic [DTSE_LEVEL_W-1:0] level;
  logic [4:0]              seq_len;
  logic [DTSE_SYM_W-1:0]   seq_mem [DTSE_SEQ_MAX];
  logic [DTSE_FREQ_W-1:0]  freq_tab [8];
  dtse_mode_t              mode;
  logic                    wr_req;
  logic                    cmd_send;
  logic                    cmd_stop;
  logic                    cmd_load;
  // Sequencer
  dtse_state_t             state;
  logic [3:0]              pos;
  logic [15:0]             bursts_done;
  logic [DTSE_TIME_W-1:0]  ms_left;
  logic [23:0]             tick_cnt;
  logic                    tick;
  logic                    last_sym;
  logic                    push;
  logic                    sym_new;
  logic                    fifo_in_ready;
  dtse_tone_t              next_tone;
  logic [DTSE_TONE_W-1:0]  fifo_out;
  logic                    fifo_out_valid;

  assign mode     = dtse_mode_t'(ctrl_bits[DTSE_MODE_LSB +: 2]);
  assign wr_req   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign cmd_send = wr_req && wb_adr_i == DTSE_CMD_ADDR && wb_dat_i[DTSE_SEND_BIT];
  assign cmd_stop = wr_req && wb_adr_i == DTSE_CMD_ADDR && wb_dat_i[DTSE_STOP_BIT];
  assign cmd_load = wr_req && wb_adr_i == DTSE_CMD_ADDR && wb_dat_i[DTSE_LOAD_BIT];

  // Bus ack: registered, one wait state, dropped the cycle after
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Configuration writes; low byte lane gates every field for simplicity
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_bits   <= '0;
      twist       <= '0;
      on_time     <= '0;
      off_time    <= '0;
      burst_count <= '0;
      level       <= DTSE_LEVEL_W'(DTSE_RESET_LEVEL);
      seq_len     <= '0;
    end
    else if (wr_req)
    begin
      case (wb_adr_i)
        DTSE_CTRL_ADDR:
        begin
          ctrl_bits <= wb_dat_i[4:0];
          twist     <= wb_dat_i[DTSE_TWIST_LSB +: DTSE_TWIST_W];
        end
        DTSE_ONTIME_ADDR:  on_time     <= wb_dat_i[DTSE_TIME_W-1:0];
        DTSE_OFFTIME_ADDR: off_time    <= wb_dat_i[DTSE_TIME_W-1:0];
        DTSE_BURSTS_ADDR:  burst_count <= wb_dat_i[15:0];
        DTSE_LEVEL_ADDR:   level       <= wb_dat_i[DTSE_LEVEL_W-1:0];
        DTSE_SEQLEN_ADDR:  seq_len     <= (wb_dat_i[4:0] > 5'h10) ? 5'h10 : wb_dat_i[4:0];
        default: ;
      endcase
    end
  end

  // Sequence symbols and tone table: one word per entry
  generate
    for (genvar i = 0; i < DTSE_SEQ_MAX; i++)
    begin : g_seq
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          seq_mem[i] <= '0;
        else if (wr_req && wb_adr_i == DTSE_SEQ_ADDR + 8'(4 * i))
          seq_mem[i] <= wb_dat_i[DTSE_SYM_W-1:0];
      end
    end
    for (genvar f = 0; f < 8; f++)
    begin : g_freq
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          freq_tab[f] <= DTSE_STD_FREQ[f];
        else if (cmd_load)
          freq_tab[f] <= DTSE_STD_FREQ[f];
        else if (wr_req && wb_adr_i == DTSE_FREQ_ADDR + 8'(4 * f))
          freq_tab[f] <= wb_dat_i[DTSE_FREQ_W-1:0];
      end
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wb_dat_o <= '0;
    else
    begin
      wb_dat_o <= '0;
      if (wb_adr_i >= DTSE_FREQ_ADDR && wb_adr_i < DTSE_FREQ_ADDR + 8'h20)
        wb_dat_o <= 32'(freq_tab[wb_adr_i[4:2]]);
      else if (wb_adr_i >= DTSE_SEQ_ADDR && wb_adr_i < DTSE_FREQ_ADDR)
        wb_dat_o <= 32'(seq_mem[wb_adr_i[5:2]]);
      else
        case (wb_adr_i)
          DTSE_CTRL_ADDR:    wb_dat_o <= {16'h0000, twist, 3'h0, ctrl_bits};
          DTSE_ONTIME_ADDR:  wb_dat_o <= 32'(on_time);
          DTSE_OFFTIME_ADDR: wb_dat_o <= 32'(off_time);
          DTSE_BURSTS_ADDR:  wb_dat_o <= 32'(burst_count);
          DTSE_LEVEL_ADDR:   wb_dat_o <= 32'(level);
          DTSE_SEQLEN_ADDR:  wb_dat_o <= 32'(seq_len);
          DTSE_STATUS_ADDR:  wb_dat_o <= {24'h0, pos, 2'b00, state};
          default:           wb_dat_o <= '0;
        endcase
    end
  end

  // Millisecond tick, restarted at each symbol edge so times are exact
  assign tick = tick_cnt == 24'(TICK_CYC - 1);
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      tick_cnt <= '0;
    else if (state == DTSE_IDLE || tick || (sym_new && !push) || (push && on_time == '0))
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  assign last_sym = {1'b0, pos} == seq_len - 5'h01;
  // A symbol is pushed once, at the start of its on time; a full FIFO stalls the sequencer
  assign push = (state == DTSE_ON) && sym_new && fifo_in_ready;

  // Sequencer state machine
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state       <= DTSE_IDLE;
      pos         <= '0;
      bursts_done <= '0;
      ms_left     <= '0;
      sym_new     <= 1'b0;
    end
    else if (cmd_stop)
    begin
      state   <= DTSE_IDLE;
      pos     <= '0;
      sym_new <= 1'b0;
    end
    else
    begin
      case (state)
        DTSE_IDLE:
          if (cmd_send && seq_len != 5'h00)
          begin
            state       <= DTSE_ON;
            ms_left     <= on_time;
            sym_new     <= 1'b1;
            bursts_done <= '0;
            if (mode != DTSE_STEP)
              pos <= '0;
          end
        DTSE_ON:
        begin
          if (push)
            sym_new <= 1'b0;
          if ((push || !sym_new) && (on_time == '0 || (tick && ms_left <= 16'h0001)))
          begin
            state   <= DTSE_OFF;
            ms_left <= off_time;
          end
          else if ((push || !sym_new) && tick) // Time runs only once the tone is queued
            ms_left <= ms_left - 1'b1;
        end
        DTSE_OFF:
          if (ms_left == '0 || (tick && ms_left == 16'h0001))
          begin
            pos     <= last_sym ? 4'h0 : pos + 1'b1;
            ms_left <= on_time;
            sym_new <= 1'b1;
            state   <= DTSE_ON;
            if (mode == DTSE_STEP)
              state <= DTSE_IDLE;
            else if (last_sym && mode == DTSE_SINGLE)
              state <= DTSE_IDLE;
            else if (last_sym && mode == DTSE_BURST)
            begin
              bursts_done <= bursts_done + 1'b1;
              if (bursts_done + 16'h0001 >= burst_count)
                state <= DTSE_IDLE;
            end
            // Continuous mode just wraps pos and keeps going
          end
          else if (tick)
            ms_left <= ms_left - 1'b1;
        default: state <= DTSE_IDLE;
      endcase
    end
  end

  // Symbol to keypad row/column, then twist and emphasis split of the peak level
  always_comb
  begin
    logic [3:0]              sym;
    logic [1:0]              row;
    logic [1:0]              col;
    logic signed [9:0]       tilt;
    logic [DTSE_LEVEL_W+7:0] hi_part;
    sym  = seq_mem[pos];
    // Codes: 0-9 digits, a=*, b=#, c-f = A-D
    case (sym)
      4'h1: {row, col} = {2'd0, 2'd0};
      4'h2: {row, col} = {2'd0, 2'd1};
      4'h3: {row, col} = {2'd0, 2'd2};
      4'h4: {row, col} = {2'd1, 2'd0};
      4'h5: {row, col} = {2'd1, 2'd1};
      4'h6: {row, col} = {2'd1, 2'd2};
      4'h7: {row, col} = {2'd2, 2'd0};
      4'h8: {row, col} = {2'd2, 2'd1};
      4'h9: {row, col} = {2'd2, 2'd2};
      4'ha: {row, col} = {2'd3, 2'd0};
      4'h0: {row, col} = {2'd3, 2'd1};
      4'hb: {row, col} = {2'd3, 2'd2};
      default: {row, col} = {2'd0, 2'(sym - 4'hc) + 2'd0} | 4'h3;
    endcase
    if (sym >= 4'hc)
      {row, col} = {2'(sym - 4'hc), 2'd3};
    // Linear tilt approximation: each unit of twist shifts 1/256 of the peak
    tilt = 10'(signed'(twist));
    if (ctrl_bits[DTSE_PREEMP_BIT])
      tilt = tilt + 10'sd32;
    if (tilt > 10'sd127)
      tilt = 10'sd127;
    else if (tilt < -10'sd127)
      tilt = -10'sd127;
    hi_part = 20'(level) * 20'(10'(128 + tilt));
    next_tone.row_freq   = freq_tab[row];
    next_tone.col_freq   = freq_tab[4 + 32'(col)];
    next_tone.high_level = hi_part[DTSE_LEVEL_W+7:8];
    next_tone.low_level  = level - hi_part[DTSE_LEVEL_W+7:8];
  end

  dtse_fifo #(
    .WIDTH (DTSE_TONE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_data   (next_tone),
    .in_valid  (push && level != '0),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (tone_ready && !tone_valid),
    .flush     (cmd_stop)
  );

  // Output registers; stop drops the pending tone at once
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tone_valid        <= 1'b0;
      tone_data         <= '0;
      tone_output_route <= 1'b0;
      preemp_en         <= 1'b0;
      dc_coupling       <= 1'b0;
      sending           <= 1'b0;
    end
    else
    begin
      if (cmd_stop)
        tone_valid <= 1'b0;
      else if (tone_ready && !tone_valid && fifo_out_valid)
      begin
        tone_valid <= 1'b1;
        tone_data  <= fifo_out;
      end
      else if (tone_valid && tone_ready)
        tone_valid <= 1'b0;
      tone_output_route <= ctrl_bits[DTSE_ROUTE_BIT];
      preemp_en         <= ctrl_bits[DTSE_PREEMP_BIT];
      dc_coupling       <= ctrl_bits[DTSE_ROUTE_BIT] && ctrl_bits[DTSE_DCCPL_BIT];
      sending           <= state != DTSE_IDLE;
    end
  end
endmodule : dtse_top
`default_nettype wire
